/* File: rtl/acs_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// RULE1: Conversion spans at least twelve bit periods
// RULE2: Select field picks 2, 8, 32 or RC
// RULE3: Software keeps bit period at least 1.6us
// RULE4: Software respects divider frequency ceilings
// RULE5: Above 1MHz, RC clock only in sleep
// RULE6: Two bit period wait, capacitor disconnected
// RULE7: Software waits acquisition before starting
// RULE8: Clearing go aborts, result unchanged
// RULE9: After abort, wait two, then acquire
// RULE10: Short first segment, then eleven bit periods
// RULE11: Software never starts while powering on
// RULE12: Completion loads result, clears go
// RULE13: Completion sets the done flag
// RULE14: Justify result, pad six zeros
// RULE15: Format one right, zero left justified
// RULE16: Result bytes writable registers when disabled
// RULE17: Analog pins read as zero
// RULE18: Pin direction never gates conversion
// RULE19: Software sets analog pins as inputs
// RULE20: RC mode waits one instruction cycle
// RULE21: Completion in sleep with enable wakes
// RULE22: Sleep with oscillator clock aborts, powers down
// RULE23: Reset powers off and aborts conversion
// RULE24: Divider restarts when conversion starts
module acs_sequencer (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       SYS_RST,
    // Control bits from software
    input  wire logic [1:0] CONV_CLK_SEL,
    input  wire logic [2:0] CHANNEL_SEL,
    input  wire logic       CONV_POWER_ON,
    input  wire logic       RESULT_FORMAT,
    input  wire logic       CONV_IRQ_ENABLE,
    input  wire logic       GO_SET,
    input  wire logic       GO_CLEAR,
    input  wire logic       DONE_FLAG_CLEAR,
    input  wire logic       SLEEP_MODE,
    // Software writes to the result bytes
    input  wire logic       RESULT_HIGH_WR,
    input  wire logic       RESULT_LOW_WR,
    input  wire logic [7:0] RESULT_WDATA,
    // Analog front end and pins
    input  wire logic       RC_CLK,
    input  wire logic       COMPARATOR,
    input  wire logic [4:0] PORT_PIN_IN,
    input  wire logic [4:0] ANALOG_PIN_MASK,
    // Status
    output logic            GO_DONE,
    output logic            CONV_DONE_FLAG,
    output logic [7:0]      RESULT_HIGH,
    output logic [7:0]      RESULT_LOW,
    output logic            WAKE_REQ,
    output logic            CONV_ACTIVE,
    // Analog control
    output logic            HOLD_CONNECT,
    output logic [2:0]      ANALOG_CHANNEL,
    output logic [9:0]      DAC_CODE,
    output logic [4:0]      PORT_READ
);
    typedef struct packed {
        acs_pkg::acs_state_t st;
        logic                go;
        logic                flag;
        logic [7:0]          res_hi;
        logic [7:0]          res_lo;
        logic [9:0]          sar;
        logic [3:0]          bit_cnt;
        logic [2:0]          icnt;
        logic                hold_on;
        logic                wake;
        logic                active;
        logic [2:0]          chan;
        logic [4:0]          port_read;
        logic                rc_s1;
        logic                rc_s2;
        logic                rc_s3;
        logic                cmp_s1;
        logic                cmp_s2;
    } acs_seq_t;

    acs_seq_t cur;
    acs_seq_t next_cur;
    logic     tick;
    logic     restart;
    logic     accept;
    logic     abort;
    logic     rc_edge;

    // Keep the trial bit if the input is above the trial, then try the next
    function automatic logic [9:0] sar_step(input logic [9:0] sar, input logic [3:0] k,
                                            input logic above);
        logic [9:0] v;
        int         b;
        v = sar;
        b = acs_pkg::RESULT_BITS - int'(k);
        if (!above) begin
            v[b] = 1'b0;
        end
        if (b > 0) begin
            v[b-1] = 1'b1;
        end
        sar_step = v;
    endfunction

    // Edge taken from the second and third stages only
    assign rc_edge = cur.rc_s2 & ~cur.rc_s3;
    assign accept  = (cur.st == acs_pkg::ACS_IDLE) && GO_SET && CONV_POWER_ON;
    // Oscillator-clocked conversion cannot survive sleep
    assign abort   = (cur.st == acs_pkg::ACS_START || cur.st == acs_pkg::ACS_CONV)
                     && (GO_CLEAR || !CONV_POWER_ON
                         || (SLEEP_MODE && CONV_CLK_SEL != acs_pkg::SEL_RC)); // RULE8 RULE22
    // Abort restarts the divider so a divider-clocked hold-off spans two full bit periods
    assign restart = accept || abort; // RULE24 RULE9

    acs_bit_timer u_timer (
        .clk          (SYS_CLK),
        .rst          (SYS_RST),
        .restart      (restart),
        .conv_clk_sel (CONV_CLK_SEL),
        .rc_edge      (rc_edge),
        .tick         (tick)
    );

    always_comb begin
        logic       sleep_abort;
        logic       finish;
        logic [9:0] final_code;
        sleep_abort = 1'b0;
        finish = 1'b0;
        final_code = 10'h000;
        next_cur = cur;
        next_cur.rc_s1 = RC_CLK;
        next_cur.rc_s2 = cur.rc_s1;
        next_cur.rc_s3 = cur.rc_s2;
        next_cur.cmp_s1 = COMPARATOR;
        next_cur.cmp_s2 = cur.cmp_s1;
        next_cur.chan = CHANNEL_SEL;
        next_cur.wake = 1'b0;
        next_cur.port_read = PORT_PIN_IN & ~ANALOG_PIN_MASK; // RULE17
        // Oscillator-clocked conversion cannot survive sleep
        sleep_abort = SLEEP_MODE && (CONV_CLK_SEL != acs_pkg::SEL_RC); // RULE22
        next_cur.active = CONV_POWER_ON && !sleep_abort; // RULE22

        // Software writes; a completing conversion below overrides them
        if (RESULT_HIGH_WR) begin
            next_cur.res_hi = RESULT_WDATA; // RULE16
        end
        if (RESULT_LOW_WR) begin
            next_cur.res_lo = RESULT_WDATA; // RULE16
        end
        if (DONE_FLAG_CLEAR) begin
            next_cur.flag = 1'b0;
        end

        unique case (cur.st)
            acs_pkg::ACS_IDLE: begin
                next_cur.hold_on = next_cur.active;
                if (accept && !sleep_abort) begin
                    next_cur.go = 1'b1;
                    next_cur.icnt = 3'h0;
                    next_cur.st = acs_pkg::ACS_START;
                end
            end
            acs_pkg::ACS_START: begin
                // At least one instruction cycle, then the next bit period edge
                if (cur.icnt != acs_pkg::INSTR_CYCLE_CLKS - 3'h1) begin
                    next_cur.icnt = cur.icnt + 3'h1; // RULE20 RULE10
                end else if (tick) begin
                    next_cur.hold_on = 1'b0;
                    next_cur.sar = acs_pkg::SAR_FIRST_TRIAL;
                    next_cur.bit_cnt = 4'h0;
                    next_cur.st = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                // Comparator lags two clocks through cmp_s1 and cmp_s2: divide-by-2 periods are too short for it
                if (tick) begin
                    next_cur.bit_cnt = cur.bit_cnt + 4'h1;
                    if (cur.bit_cnt != 4'h0) begin
                        next_cur.sar = sar_step(cur.sar, cur.bit_cnt, cur.cmp_s2); // RULE10
                    end
                    // Eleven bit periods after the first segment
                    finish = (cur.bit_cnt == acs_pkg::CONV_BIT_PERIODS - 4'h1); // RULE1
                    final_code = finish ? next_cur.sar : 10'h000;
                end
            end
            acs_pkg::ACS_HOLDOFF: begin
                next_cur.hold_on = 1'b0; // RULE6
                if (tick) begin
                    next_cur.bit_cnt = cur.bit_cnt + 4'h1;
                    if (cur.bit_cnt == acs_pkg::HOLDOFF_BIT_PERIODS - 4'h1) begin
                        next_cur.st = acs_pkg::ACS_IDLE; // RULE9
                    end
                end
            end
            default: begin
                next_cur.st = acs_pkg::ACS_IDLE;
            end
        endcase

        if (cur.st == acs_pkg::ACS_START || cur.st == acs_pkg::ACS_CONV) begin
            if (abort) begin
                // Abort leaves the result pair untouched
                finish = 1'b0; // RULE8
                next_cur.go = 1'b0;
                next_cur.bit_cnt = 4'h0;
                next_cur.hold_on = 1'b0;
                next_cur.st = acs_pkg::ACS_HOLDOFF; // RULE9
            end else if (finish) begin
                if (RESULT_FORMAT) begin
                    next_cur.res_hi = {6'h00, final_code[9:8]}; // RULE15 RULE14
                    next_cur.res_lo = final_code[7:0];
                end else begin
                    next_cur.res_hi = final_code[9:2]; // RULE15 RULE14
                    next_cur.res_lo = {final_code[1:0], 6'h00};
                end
                next_cur.go = 1'b0; // RULE12
                next_cur.flag = 1'b1; // RULE13
                next_cur.wake = SLEEP_MODE && CONV_IRQ_ENABLE; // RULE21
                next_cur.bit_cnt = 4'h0;
                next_cur.st = acs_pkg::ACS_HOLDOFF; // RULE6
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cur <= '0; // RULE23
            cur.st <= acs_pkg::ACS_IDLE;
            cur.res_hi <= acs_pkg::RESULT_RESET;
            cur.res_lo <= acs_pkg::RESULT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Pin direction is not an input here: any pin level is converted (RULE18)
    assign GO_DONE        = cur.go;
    assign CONV_DONE_FLAG = cur.flag;
    assign RESULT_HIGH    = cur.res_hi;
    assign RESULT_LOW     = cur.res_lo;
    assign WAKE_REQ       = cur.wake;
    assign CONV_ACTIVE    = cur.active;
    assign HOLD_CONNECT   = cur.hold_on;
    assign ANALOG_CHANNEL = cur.chan;
    assign DAC_CODE       = cur.sar;
    assign PORT_READ      = cur.port_read;
endmodule // acs_sequencer

/* File: pkg/acs_pkg.sv */
package acs_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        ACS_IDLE,
        ACS_START,
        ACS_CONV,
        ACS_HOLDOFF
    } acs_state_t;

    // Clock period of the device oscillator, in picoseconds
    localparam int CLK_PERIOD_PS = 5000;

    // Conversion clock select codes
    localparam logic [1:0] SEL_DIV2  = 2'h0;
    localparam logic [1:0] SEL_DIV8  = 2'h1;
    localparam logic [1:0] SEL_DIV32 = 2'h2;
    localparam logic [1:0] SEL_RC    = 2'h3;

    // Oscillator periods per bit period, per select code
    localparam logic [5:0] DIV2_CLKS  = 6'h02;
    localparam logic [5:0] DIV8_CLKS  = 6'h08;
    localparam logic [5:0] DIV32_CLKS = 6'h20;

    // Oscillator periods per instruction cycle
    localparam logic [2:0] INSTR_CYCLE_CLKS = 3'h4;

    // Result geometry
    localparam int RESULT_BITS = 10;
    localparam logic [RESULT_BITS-1:0] SAR_FIRST_TRIAL = 10'h200;

    // Bit periods after the first segment, and wait after finish or abort
    localparam logic [3:0] CONV_BIT_PERIODS    = 4'hB;
    localparam logic [3:0] HOLDOFF_BIT_PERIODS = 4'h2;

    // Result reset value and pin count
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam int         PIN_COUNT    = 5;
endpackage

/* File: rtl/acs_bit_timer.sv */
`timescale 1ns/1ps
module acs_bit_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       restart,
    input  wire logic [1:0] conv_clk_sel,
    input  wire logic       rc_edge,
    // Bit period strobe
    output logic            tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } acs_timer_t;

    acs_timer_t cur;
    acs_timer_t next_cur;

    function automatic logic [5:0] div_clks(input logic [1:0] sel);
        unique case (sel)
            acs_pkg::SEL_DIV2:  div_clks = acs_pkg::DIV2_CLKS;
            acs_pkg::SEL_DIV8:  div_clks = acs_pkg::DIV8_CLKS;
            default:            div_clks = acs_pkg::DIV32_CLKS;
        endcase
    endfunction

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (restart) begin
            next_cur.cnt = 6'h00; // RULE24
        end else if (conv_clk_sel == acs_pkg::SEL_RC) begin
            next_cur.cnt = 6'h00;
            next_cur.tick = rc_edge;
        end else if (cur.cnt >= div_clks(conv_clk_sel) - 6'h01) begin
            next_cur.cnt = 6'h00; // RULE2
            next_cur.tick = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;
endmodule // acs_bit_timer

/* File: verification/acs_properties.sv */
`timescale 1ns/1ps
module acs_properties (
    // Clock and reset
    input wire logic       SYS_CLK,
    input wire logic       SYS_RST,
    // Controls
    input wire logic [1:0] CONV_CLK_SEL,
    input wire logic       CONV_POWER_ON,
    input wire logic       RESULT_FORMAT,
    input wire logic       CONV_IRQ_ENABLE,
    input wire logic       SLEEP_MODE,
    // Status
    input wire logic       GO_DONE,
    input wire logic       CONV_DONE_FLAG,
    input wire logic [7:0] RESULT_HIGH,
    input wire logic [7:0] RESULT_LOW,
    input wire logic       WAKE_REQ,
    input wire logic       CONV_ACTIVE,
    input wire logic       HOLD_CONNECT
);
    logic [9:0] busy_len;
    logic [9:0] next_busy_len;
    always_comb next_busy_len = GO_DONE ? busy_len + 10'h001 : 10'h000;
    always_ff @(posedge SYS_CLK) busy_len <= SYS_RST ? 10'h000 : next_busy_len;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    chk_done_clears_go: assert property (
        $rose(CONV_DONE_FLAG) |-> $fell(GO_DONE)) else $error("flag rose, go held");
    chk_min_conv_len: assert property (
        $rose(CONV_DONE_FLAG) |-> busy_len >= 10'h017) else $error("conversion too short");
    chk_right_pad: assert property (
        $rose(CONV_DONE_FLAG) && $past(RESULT_FORMAT) |-> RESULT_HIGH[7:2] == 6'h00)
        else $error("right format high pad");
    chk_left_pad: assert property (
        $rose(CONV_DONE_FLAG) && !$past(RESULT_FORMAT) |-> RESULT_LOW[5:0] == 6'h00)
        else $error("left format low pad");
    chk_abort_keeps: assert property (
        $fell(GO_DONE) && !$rose(CONV_DONE_FLAG) |-> $stable(RESULT_HIGH) && $stable(RESULT_LOW))
        else $error("abort touched result");
    chk_holdoff_gap: assert property (
        $fell(GO_DONE) |-> !HOLD_CONNECT [*3]) else $error("capacitor back too soon");
    chk_reacquire: assert property (
        $fell(GO_DONE) && CONV_ACTIVE && CONV_POWER_ON && !SLEEP_MODE |-> ##[1:100] HOLD_CONNECT)
        else $error("no acquisition after holdoff");
    chk_wake_cause: assert property (
        WAKE_REQ |-> $past(SLEEP_MODE) && $past(CONV_IRQ_ENABLE) && $rose(CONV_DONE_FLAG))
        else $error("wake without cause");
    chk_sleep_abort: assert property (
        SLEEP_MODE && CONV_CLK_SEL != 2'h3 |-> ##[1:3] !(GO_DONE || CONV_ACTIVE))
        else $error("sleep did not stop converter");
    chk_first_seg: assert property (
        $rose(GO_DONE) |-> HOLD_CONNECT [*2] ##[1:40] !HOLD_CONNECT)
        else $error("first segment length");
endmodule // acs_properties

/* File: verification/acs_analog_model.sv */
`timescale 1ns/1ps
module acs_analog_model (
    // Trial code and input level
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] level,
    // Front end answers
    output logic            comparator,
    output logic            rc_clk
);
    // Free running, phase unrelated to the system clock
    initial rc_clk = 1'b0;
    always #18.3 rc_clk = ~rc_clk;
    // Pin direction is not modelled: any level on the pin is converted
    assign comparator = level >= dac_code;
endmodule // acs_analog_model

/* File: verification/acs_sequencer_tb.sv */
`timescale 1ns/1ps
module acs_sequencer_tb;
    typedef struct packed {
        logic [1:0]  sel;
        logic        fmt;
        logic        slp;
        logic [9:0]  lvl;
        logic [15:0] res;
    } acs_row_t;
    logic       sys_clk, sys_rst, pwr, fmt, irq, go_set, go_clr, flag_clr, slp, wr_hi, wr_lo;
    logic       rc_clk, comp, go_done, flag, wake, active, hold, woke;
    logic [1:0] sel;
    logic [2:0] chan, a_chan;
    logic [7:0] wdata, res_hi, res_lo;
    logic [4:0] pins, mask, port_rd;
    logic [9:0] lvl, dac;
    int         n_fail, checks_done;
    acs_row_t   rows [4] = '{
        '{2'h0, 1'b1, 1'b0, 10'h3FF, 16'h03FF},
        '{2'h1, 1'b0, 1'b0, 10'h155, 16'h5540},
        '{2'h2, 1'b1, 1'b0, 10'h2AA, 16'h02AA},
        '{2'h3, 1'b0, 1'b1, 10'h001, 16'h0040}};

    always #2.5 sys_clk = ~sys_clk;

    acs_sequencer i_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CONV_CLK_SEL(sel),
        .CHANNEL_SEL(chan), .CONV_POWER_ON(pwr), .RESULT_FORMAT(fmt), .CONV_IRQ_ENABLE(irq),
        .GO_SET(go_set), .GO_CLEAR(go_clr), .DONE_FLAG_CLEAR(flag_clr), .SLEEP_MODE(slp),
        .RESULT_HIGH_WR(wr_hi), .RESULT_LOW_WR(wr_lo), .RESULT_WDATA(wdata), .RC_CLK(rc_clk),
        .COMPARATOR(comp), .PORT_PIN_IN(pins), .ANALOG_PIN_MASK(mask), .GO_DONE(go_done),
        .CONV_DONE_FLAG(flag), .RESULT_HIGH(res_hi), .RESULT_LOW(res_lo), .WAKE_REQ(wake),
        .CONV_ACTIVE(active), .HOLD_CONNECT(hold), .ANALOG_CHANNEL(a_chan), .DAC_CODE(dac),
        .PORT_READ(port_rd));
    acs_analog_model i_afe (.dac_code(dac), .level(lvl), .comparator(comp), .rc_clk(rc_clk));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait: 0 for capacitor reconnect, 1 for go to drop
    task automatic await(input int k);
        for (int i = 0; i < 600; i++) begin
            woke |= (wake === 1'b1);
            if (k == 0 ? hold === 1'b1 : go_done === 1'b0) return;
            step(1);
        end
        n_fail++;
        stop_test();
    endtask
    task automatic start();
        await(0);
        step(4);
        go_set = 1'b1;
        step(1);
        go_set = 1'b0;
    endtask
    task automatic conv(input acs_row_t r);
        // Bit periods scaled down to keep the run short; RC row runs asleep
        sel = r.sel;
        fmt = r.fmt;
        lvl = r.lvl;
        woke = 1'b0;
        start();
        slp = r.slp;
        await(1);
        check({res_hi, res_lo}, r.res);
        check({15'h0000, flag}, 16'h0001);
        check({15'h0000, woke}, {15'h0000, r.slp});
        slp = 1'b0;
        flag_clr = 1'b1;
        step(1);
        flag_clr = 1'b0;
        await(0);
        check({15'h0000, flag}, 16'h0000);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {sys_clk, pwr, fmt, irq, go_set, go_clr, flag_clr, slp, wr_hi, wr_lo, woke} = '0;
        {sel, chan, wdata, pins, mask, lvl} = '0;
        sys_rst = 1'b1;
        n_fail = 0;
        checks_done = 0;
        step(2);
        sys_rst = 1'b0;
        check({res_hi, res_lo}, 16'h0000);
        check({12'h000, go_done, flag, active, hold}, 16'h0000);
        // Analog pins are taken to be set as inputs
        {irq, chan, mask, pins} = {1'b1, 3'h2, 5'h15, 5'h1F};
        pwr = 1'b1;
        step(4);
        check({11'h000, port_rd}, 16'h000A);
        check({13'h0000, a_chan}, 16'h0002);
        foreach (rows[i]) conv(rows[i]);
        // Abort in mid-conversion leaves the last result
        sel = 2'h2;
        start();
        step(60);
        go_clr = 1'b1;
        step(1);
        go_clr = 1'b0;
        step(2);
        check({14'h0000, go_done, flag}, 16'h0000);
        check({res_hi, res_lo}, 16'h0040);
        await(0);
        // Sleep with an oscillator clock stops the converter
        sel = 2'h1;
        start();
        step(30);
        slp = 1'b1;
        step(4);
        check({14'h0000, go_done, active}, 16'h0000);
        slp = 1'b0;
        await(0);
        // Reset in mid-conversion aborts and clears everything
        sel = 2'h2;
        start();
        step(50);
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        check({res_hi, res_lo}, 16'h0000);
        check({12'h000, go_done, flag, active, hold}, 16'h0000);
        // Powered off, the result bytes are plain storage
        pwr = 1'b0;
        wdata = 8'hA5;
        wr_hi = 1'b1;
        step(1);
        wr_hi = 1'b0;
        wdata = 8'h5A;
        wr_lo = 1'b1;
        step(1);
        wr_lo = 1'b0;
        step(1);
        check({res_hi, res_lo}, 16'hA55A);
        stop_test();
    end
endmodule // acs_sequencer_tb

bind acs_sequencer acs_properties i_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .CONV_CLK_SEL(CONV_CLK_SEL), .CONV_POWER_ON(CONV_POWER_ON), .RESULT_FORMAT(RESULT_FORMAT),
    .CONV_IRQ_ENABLE(CONV_IRQ_ENABLE), .SLEEP_MODE(SLEEP_MODE), .GO_DONE(GO_DONE),
    .CONV_DONE_FLAG(CONV_DONE_FLAG), .RESULT_HIGH(RESULT_HIGH), .RESULT_LOW(RESULT_LOW),
    .WAKE_REQ(WAKE_REQ), .CONV_ACTIVE(CONV_ACTIVE), .HOLD_CONNECT(HOLD_CONNECT));
